// [src/pcpc_pkg.sv]
package pcpc_pkg;
    // Port geometry
    localparam int NPORT = 5;
    localparam int NXPORT = 4;
    localparam int NPIN = 40;
    localparam int NXPIN = 32;
    localparam int FSEL_W = 5;
    // Register addresses on the special function register bus
    localparam logic [7:0] FSEL0_ADDR = 8'hE1;
    localparam logic [7:0] FSEL1_ADDR = 8'hE2;
    localparam logic [7:0] FSEL2_ADDR = 8'hE3;
    localparam logic [7:0] LATCH_ADDR [NPORT] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC7};
    localparam logic [7:0] SKIP_ADDR [NXPORT] = '{8'hD4, 8'hD5, 8'hD6, 8'hD7};
    localparam logic [7:0] MDIN_ADDR [NPORT] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5};
    localparam logic [7:0] MDOUT_ADDR [NPORT] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAE};
    // Reset values
    localparam logic [7:0] LATCH_RST = 8'hFF;
    localparam logic [7:0] MDIN_RST = 8'hFF;
    localparam logic [7:0] MDOUT_RST = 8'h00;
    localparam logic [7:0] SKIP_RST = 8'h00;
    localparam logic [7:0] FSEL_RST = 8'h00;
    localparam logic [7:0] FSEL2_MASK = 8'h03;
    localparam logic [7:0] RD_NONE = 8'h00;
    // Field positions
    localparam int B0_SER0 = 0;
    localparam int B0_SPI = 1;
    localparam int B0_TW0 = 2;
    localparam int B0_SYSCLK = 3;
    localparam int B0_CMP0 = 4;
    localparam int B0_CMP0A = 5;
    localparam int B0_CMP1 = 6;
    localparam int B0_CMP1A = 7;
    localparam int B1_CNT_LSB = 0;
    localparam int B1_CNT_MSB = 2;
    localparam int B1_ECI = 3;
    localparam int B1_T0 = 4;
    localparam int B1_T1 = 5;
    localparam int B1_XBE = 6;
    localparam int B1_PUD = 7;
    localparam int B2_SER1 = 0;
    localparam int B2_TW1 = 1;
    localparam logic [2:0] CNT_MAX = 3'h5;
    localparam logic [1:0] NSS_3WIRE = 2'h0;
    // Function indices in priority order
    typedef enum int {
        FN_SER0_TX, FN_SER0_RX, FN_SCK, FN_MISO, FN_MOSI, FN_NSS,
        FN_TW0_SDA, FN_TW0_SCL, FN_CMP0, FN_CMP0A, FN_CMP1, FN_CMP1A,
        FN_SYSCLK, FN_COUNTER_MODULE0_IO, FN_CEX1, FN_CEX2, FN_CEX3, FN_CEX4,
        FN_ECI, FN_T0, FN_T1, FN_TW1_SDA, FN_TW1_SCL, FN_SER1_TX,
        FN_SER1_RX, NFUNC
    } pcpc_func_t;
    localparam int NCEX = 5;
    localparam int SER0_TX_PIN = 4;
    localparam int SER0_RX_PIN = 5;
endpackage

// [src/pcpc_map_if.sv]
`timescale 1ns/100ps
interface pcpc_map_if;
    import pcpc_pkg::*;
    logic [NFUNC-1:0] req;
    logic [NXPIN-1:0] skip;
    logic [NXPIN-1:0] pin_valid;
    logic [FSEL_W-1:0] pin_sel [NXPIN];
    modport cfg (output req, output skip, input pin_valid, input pin_sel);
    modport dec (input req, input skip, output pin_valid, output pin_sel);
endinterface

// [src/pcpc_decoder.sv]
`timescale 1ns/100ps
module pcpc_decoder
    import pcpc_pkg::*;
(
    pcpc_map_if.dec map
);
    logic [NXPIN-1:0] used;
    logic found;

    // Priority search over the function list
    always_comb begin
        used = map.skip; // RULE4
        found = 1'b0;
        map.pin_valid = '0;
        for (int p = 0; p < NXPIN; p++) begin
            map.pin_sel[p] = '0;
        end
        if (map.req[FN_SER0_TX]) begin
            used[SER0_TX_PIN] = 1'b1; // RULE3
            used[SER0_RX_PIN] = 1'b1;
            map.pin_valid[SER0_TX_PIN] = 1'b1;
            map.pin_valid[SER0_RX_PIN] = 1'b1;
            map.pin_sel[SER0_TX_PIN] = FSEL_W'(FN_SER0_TX);
            map.pin_sel[SER0_RX_PIN] = FSEL_W'(FN_SER0_RX);
        end
        // Each enabled function takes the lowest free pin
        for (int k = FN_SCK; k < NFUNC; k++) begin // RULE1
            found = 1'b0;
            if (map.req[k]) begin
                for (int p = 0; p < NXPIN; p++) begin
                    if (!found && !used[p]) begin // RULE2
                        map.pin_sel[p] = FSEL_W'(k);
                        map.pin_valid[p] = 1'b1;
                        used[p] = 1'b1;
                        found = 1'b1;
                    end
                end
            end
        end
    end
endmodule

// [src/pcpc_top.sv]
`timescale 1ns/100ps
// Functional notes
// RULE1: Functions assigned pins in fixed priority order
// RULE2: Each function gets lowest free unskipped pin
// RULE3: Serial port 0 fixed on pins 4, 5
// RULE4: Skipped pins treated as already assigned
// RULE5: Paired functions claim both pins consecutively
// RULE6: Leftover pins remain general purpose I/O
// RULE7: SPI claims three or four pins
// RULE8: Input mode bit selects digital or analog
// RULE9: All pins digital inputs after reset
// RULE10: Output mode bit picks open-drain or push-pull
// RULE11: Two-wire bus pins always open-drain
// RULE12: Weak pull-up on released open-drain pins
// RULE13: Crossbar disabled keeps ports 0-3 inputs
// RULE14: Port 4 is always plain I/O
// RULE15: Function select 0 bit layout
// RULE16: Function select 1 bit layout
// RULE17: Counter module field routes 0 to 5
// RULE18: Function select 2 holds bus1, serial1
// RULE19: Port data read returns pin levels
// RULE20: Software releases driver for digital input
// RULE21: Software enables crossbar last
// RULE22: Software skips pins claimed directly
// RULE23: Output mode ignored on analog pins
// RULE24: Mapping follows register writes next cycle
// RULE25: Skip, input, output mode per pin
module pcpc_top
    import pcpc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic [1:0] SPI_NSS_MODE,
    input wire logic [NFUNC-1:0] FN_OUT,
    input wire logic [NFUNC-1:0] FN_OE,
    output logic [NFUNC-1:0] FN_IN,
    output logic [NFUNC-1:0] FN_ROUTED,
    input wire logic [NPIN-1:0] PAD_IN,
    output logic [NPIN-1:0] PAD_OUT,
    output logic [NPIN-1:0] PAD_OE,
    output logic [NPIN-1:0] PAD_PULLUP,
    output logic [NPIN-1:0] PAD_ANALOG
);

    // Two-wire bus signals are forced open-drain
    function automatic logic is_twowire(input logic [FSEL_W-1:0] sel);
        is_twowire = (sel == FSEL_W'(FN_TW0_SDA)) || (sel == FSEL_W'(FN_TW0_SCL))
            || (sel == FSEL_W'(FN_TW1_SDA)) || (sel == FSEL_W'(FN_TW1_SCL));
    endfunction

    // Configuration registers
    logic [7:0] fsel0_r;
    logic [7:0] fsel1_r;
    logic [7:0] fsel2_r;
    logic [7:0] latch_r [NPORT];
    logic [7:0] mdin_r [NPORT];
    logic [7:0] mdout_r [NPORT];
    logic [7:0] skip_r [NXPORT];
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;

    // Pad input synchroniser and filtered level
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] sync3_r;
    logic [NPIN-1:0] lvl_r;
    logic [NPIN-1:0] lvl_nxt;

    // Per-pin drive results
    logic [NPIN-1:0] out_nxt;
    logic [NPIN-1:0] oe_nxt;
    logic [NPIN-1:0] pu_nxt;
    logic [NPIN-1:0] digital;
    logic [NPIN-1:0] out_r;
    logic [NPIN-1:0] oe_r;
    logic [NPIN-1:0] pu_r;
    logic [NPIN-1:0] analog_r;

    // Peripheral-facing results
    logic [NFUNC-1:0] fn_in_nxt;
    logic [NFUNC-1:0] fn_in_r;
    logic [NFUNC-1:0] routed_nxt;
    logic [NFUNC-1:0] routed_r;

    logic xbar_en;
    logic pud;
    logic [2:0] cnt_code;
    logic spi_4wire;

    pcpc_map_if map_if ();

    pcpc_decoder u_dec (
        .map (map_if)
    );

    assign xbar_en = fsel1_r[B1_XBE]; // RULE16
    assign pud = fsel1_r[B1_PUD];
    assign cnt_code = fsel1_r[B1_CNT_MSB:B1_CNT_LSB];
    assign spi_4wire = (SPI_NSS_MODE != NSS_3WIRE);

    // Function requests from the select registers
    assign map_if.req[FN_SER0_TX] = fsel0_r[B0_SER0]; // RULE15
    assign map_if.req[FN_SER0_RX] = fsel0_r[B0_SER0];
    assign map_if.req[FN_SCK] = fsel0_r[B0_SPI];
    assign map_if.req[FN_MISO] = fsel0_r[B0_SPI];
    assign map_if.req[FN_MOSI] = fsel0_r[B0_SPI];
    assign map_if.req[FN_NSS] = fsel0_r[B0_SPI] & spi_4wire; // RULE7
    assign map_if.req[FN_TW0_SDA] = fsel0_r[B0_TW0]; // RULE5
    assign map_if.req[FN_TW0_SCL] = fsel0_r[B0_TW0];
    assign map_if.req[FN_CMP0] = fsel0_r[B0_CMP0];
    assign map_if.req[FN_CMP0A] = fsel0_r[B0_CMP0A];
    assign map_if.req[FN_CMP1] = fsel0_r[B0_CMP1];
    assign map_if.req[FN_CMP1A] = fsel0_r[B0_CMP1A];
    assign map_if.req[FN_SYSCLK] = fsel0_r[B0_SYSCLK];
    assign map_if.req[FN_ECI] = fsel1_r[B1_ECI];
    assign map_if.req[FN_T0] = fsel1_r[B1_T0];
    assign map_if.req[FN_T1] = fsel1_r[B1_T1];
    assign map_if.req[FN_TW1_SDA] = fsel2_r[B2_TW1]; // RULE18
    assign map_if.req[FN_TW1_SCL] = fsel2_r[B2_TW1];
    assign map_if.req[FN_SER1_TX] = fsel2_r[B2_SER1];
    assign map_if.req[FN_SER1_RX] = fsel2_r[B2_SER1];

    // Counter module outputs, reserved codes route none
    genvar c;
    generate
        for (c = 0; c < NCEX; c++) begin : g_cex
            assign map_if.req[FN_COUNTER_MODULE0_IO + c] = (cnt_code > 3'(c)) && (cnt_code <= CNT_MAX); // RULE17
        end
    endgenerate

    // Skip bits of the crossbar ports
    genvar s;
    generate
        for (s = 0; s < NXPORT; s++) begin : g_skip
            assign map_if.skip[s*8 +: 8] = skip_r[s];
        end
    endgenerate

    // Function select register writes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fsel0_r <= FSEL_RST;
            fsel1_r <= FSEL_RST;
            fsel2_r <= FSEL_RST;
        end else if (SFR_WR) begin
            if (SFR_ADDR == FSEL0_ADDR) begin
                fsel0_r <= SFR_WDATA; // RULE24
            end
            if (SFR_ADDR == FSEL1_ADDR) begin
                fsel1_r <= SFR_WDATA;
            end
            if (SFR_ADDR == FSEL2_ADDR) begin
                fsel2_r <= SFR_WDATA & FSEL2_MASK;
            end
        end
    end

    // Port data latches
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int p = 0; p < NPORT; p++) begin
                latch_r[p] <= LATCH_RST;
            end
        end else if (SFR_WR) begin
            for (int p = 0; p < NPORT; p++) begin
                if (SFR_ADDR == LATCH_ADDR[p]) begin
                    latch_r[p] <= SFR_WDATA;
                end
            end
        end
    end

    // Input mode bits, all digital after reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int p = 0; p < NPORT; p++) begin
                mdin_r[p] <= MDIN_RST; // RULE9
            end
        end else if (SFR_WR) begin
            for (int p = 0; p < NPORT; p++) begin
                if (SFR_ADDR == MDIN_ADDR[p]) begin
                    mdin_r[p] <= SFR_WDATA; // RULE25
                end
            end
        end
    end

    // Output mode bits
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int p = 0; p < NPORT; p++) begin
                mdout_r[p] <= MDOUT_RST;
            end
        end else if (SFR_WR) begin
            for (int p = 0; p < NPORT; p++) begin
                if (SFR_ADDR == MDOUT_ADDR[p]) begin
                    mdout_r[p] <= SFR_WDATA;
                end
            end
        end
    end

    // Skip bits, no skip register for port 4
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int p = 0; p < NXPORT; p++) begin
                skip_r[p] <= SKIP_RST;
            end
        end else if (SFR_WR) begin
            for (int p = 0; p < NXPORT; p++) begin
                if (SFR_ADDR == SKIP_ADDR[p]) begin
                    skip_r[p] <= SFR_WDATA; // RULE24
                end
            end
        end
    end

    // Read data mux; port data reads the pins
    always_comb begin
        rdata_nxt = RD_NONE;
        case (SFR_ADDR)
            FSEL0_ADDR: rdata_nxt = fsel0_r;
            FSEL1_ADDR: rdata_nxt = fsel1_r;
            FSEL2_ADDR: rdata_nxt = fsel2_r;
            default: rdata_nxt = RD_NONE;
        endcase
        for (int p = 0; p < NPORT; p++) begin
            if (SFR_ADDR == LATCH_ADDR[p]) begin
                rdata_nxt = lvl_r[p*8 +: 8] & mdin_r[p]; // RULE19
            end
            if (SFR_ADDR == MDIN_ADDR[p]) begin
                rdata_nxt = mdin_r[p];
            end
            if (SFR_ADDR == MDOUT_ADDR[p]) begin
                rdata_nxt = mdout_r[p];
            end
        end
        for (int p = 0; p < NXPORT; p++) begin
            if (SFR_ADDR == SKIP_ADDR[p]) begin
                rdata_nxt = skip_r[p];
            end
        end
    end

    // Read data register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_r <= RD_NONE;
        end else if (SFR_RD) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Three-stage pad synchroniser
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
        end else begin
            sync1_r <= PAD_IN;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Level changes once stages two and three agree
    assign lvl_nxt = (sync2_r & sync3_r) | (lvl_r & (sync2_r ^ sync3_r));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            lvl_r <= '1;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // Pin cells
    genvar i;
    generate
        for (i = 0; i < NPIN; i++) begin : g_pin
            localparam int P = i / 8;
            localparam int B = i % 8;
            logic routed;
            logic fn_drv;
            logic fn_val;
            logic val;
            logic tw;
            logic drive_en;
            logic push_pull;
            if (i < NXPIN) begin : g_xbar
                logic [FSEL_W-1:0] sel;
                assign sel = map_if.pin_sel[i];
                assign routed = xbar_en & map_if.pin_valid[i]; // RULE6
                assign fn_drv = FN_OE[sel];
                assign fn_val = FN_OUT[sel];
                assign tw = routed & is_twowire(sel); // RULE11
                assign drive_en = digital[i] & xbar_en; // RULE13
            end else begin : g_gpio
                assign routed = 1'b0; // RULE14
                assign fn_drv = 1'b0;
                assign fn_val = 1'b1;
                assign tw = 1'b0;
                assign drive_en = digital[i];
            end
            assign digital[i] = mdin_r[P][B]; // RULE8
            // Idle or input functions release the driver
            assign val = routed ? (fn_drv ? fn_val : 1'b1) : latch_r[P][B];
            // Mode bit ignored on analog or disabled pins
            assign push_pull = mdout_r[P][B] & ~tw & drive_en; // RULE10 RULE23
            assign out_nxt[i] = push_pull & val;
            assign oe_nxt[i] = drive_en & (push_pull ? ~(routed & ~fn_drv) : ~val);
            assign pu_nxt[i] = digital[i] & ~pud & ~push_pull & ~oe_nxt[i]; // RULE12
        end
    endgenerate

    // Registered pad controls
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_r <= '0;
            oe_r <= '0;
            pu_r <= '1;
            analog_r <= '0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
            analog_r <= ~digital;
        end
    end

    // Routed pin levels back to the peripherals
    always_comb begin
        fn_in_nxt = '1;
        routed_nxt = '0;
        for (int p = 0; p < NXPIN; p++) begin
            if (xbar_en && map_if.pin_valid[p]) begin
                fn_in_nxt[map_if.pin_sel[p]] = lvl_r[p] & digital[p];
                routed_nxt[map_if.pin_sel[p]] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fn_in_r <= '1;
            routed_r <= '0;
        end else begin
            fn_in_r <= fn_in_nxt;
            routed_r <= routed_nxt;
        end
    end

    // Outputs
    assign SFR_RDATA = rdata_r;
    assign PAD_OUT = out_r;
    assign PAD_OE = oe_r;
    assign PAD_PULLUP = pu_r;
    assign PAD_ANALOG = analog_r;
    assign FN_IN = fn_in_r;
    assign FN_ROUTED = routed_r;

endmodule

// [tb/pcpc_top_props.sv]
`timescale 1ns/100ps
module pcpc_top_props
    import pcpc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic [NFUNC-1:0] FN_ROUTED,
    input wire logic [NPIN-1:0] PAD_OUT,
    input wire logic [NPIN-1:0] PAD_OE,
    input wire logic [NPIN-1:0] PAD_PULLUP,
    input wire logic [NPIN-1:0] PAD_ANALOG
);
    logic [7:0] f0_r, f1_r, f2_r, f0_d, f1_d, rd_exp;
    logic [4:0] cnt_exp;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Shadow copies of the function-select registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            f0_r <= FSEL_RST;
            f1_r <= FSEL_RST;
            f2_r <= FSEL_RST;
        end else if (SFR_WR) begin
            if (SFR_ADDR == FSEL0_ADDR) f0_r <= SFR_WDATA;
            if (SFR_ADDR == FSEL1_ADDR) f1_r <= SFR_WDATA;
            if (SFR_ADDR == FSEL2_ADDR) f2_r <= SFR_WDATA;
        end
    end
    // Delayed copies mark when the pad outputs have caught up
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            f0_d <= FSEL_RST;
            f1_d <= FSEL_RST;
        end else begin
            f0_d <= f0_r;
            f1_d <= f1_r;
        end
    end
    // Expected read data and counter module routing
    always_comb begin
        rd_exp = (SFR_ADDR == FSEL0_ADDR) ? f0_r :
                 (SFR_ADDR == FSEL1_ADDR) ? f1_r : (f2_r & FSEL2_MASK);
        cnt_exp = (f1_d[2:0] > CNT_MAX) ? 5'h00 : 5'((6'h01 << f1_d[2:0]) - 6'h01);
    end
    sequence s_fsel_rd;
        SFR_RD && SFR_ADDR[7:2] == 6'h38 && SFR_ADDR[1:0] != 2'h0;
    endsequence
    sequence s_ser0_wr;
        SFR_WR && SFR_ADDR == FSEL0_ADDR && f1_r[B1_XBE] && f1_d[B1_XBE];
    endsequence
    chk_fsel_readback: assert property (s_fsel_rd |=> SFR_RDATA == $past(rd_exp))
        else $error("function select read data wrong");
    chk_rdata_hold: assert property (!SFR_RD |=> $stable(SFR_RDATA))
        else $error("read data moved without a read");
    chk_xbar_off_quiet: assert property (!f1_r[B1_XBE] && !f1_d[B1_XBE] |->
        PAD_OE[NXPIN-1:0] == '0 && FN_ROUTED == '0) else $error("crossbar off but pins driven");
    chk_analog_quiet: assert property ((PAD_ANALOG & (PAD_OE | PAD_PULLUP)) == '0)
        else $error("analog pin drives or pulls up");
    chk_pullup_drive: assert property ((PAD_PULLUP & PAD_OE) == '0)
        else $error("pull-up on a driving pin");
    chk_pud_all_off: assert property (f1_r[B1_PUD] && f1_d[B1_PUD] |-> PAD_PULLUP == '0)
        else $error("pull-up active while disabled");
    chk_ser0_pair: assert property (f1_d[B1_XBE] && f1_r[B1_XBE] && f0_r[0] && f0_d[0]
        |-> FN_ROUTED[1:0] == 2'h3) else $error("serial pair not routed");
    chk_map_follow: assert property (s_ser0_wr |-> ##2
        FN_ROUTED[1:0] == {2{$past(SFR_WDATA[B0_SER0], 2)}}) else $error("mapping late");
    chk_cnt_field: assert property (f1_r == f1_d && f1_d[B1_XBE] |->
        FN_ROUTED[17:13] == cnt_exp) else $error("counter module routing wrong");
endmodule
bind pcpc_top pcpc_top_props pcpc_top_props_i (.CLK, .RST_N, .SFR_ADDR, .SFR_WDATA,
    .SFR_WR, .SFR_RD, .SFR_RDATA, .FN_ROUTED, .PAD_OUT, .PAD_OE, .PAD_PULLUP, .PAD_ANALOG);

// [tb/pcpc_board.sv]
`timescale 1ns/100ps
module pcpc_board
    import pcpc_pkg::*;
(
    input wire logic clk,
    input wire logic [NPIN-1:0] pad_out,
    input wire logic [NPIN-1:0] pad_oe,
    input wire logic [NPIN-1:0] pad_pullup,
    input wire logic [NPIN-1:0] ext_en,
    input wire logic [NPIN-1:0] ext_val,
    output logic [NPIN-1:0] pad_lvl
);
    logic flt_r = 1'b0;
    // Undriven, unpulled pins wander every cycle
    always_ff @(posedge clk) begin
        flt_r <= !flt_r;
    end
    // Wire level: device driver, then board driver, then pull-up or float
    assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
        (~pad_oe & ~ext_en & (pad_pullup | {NPIN{flt_r}}));
endmodule

// [tb/priority_crossbar_port_config_bench.sv]
`timescale 1ns/100ps
module priority_crossbar_port_config_bench
    import pcpc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, wr, rd;
    logic [1:0] nss;
    logic [7:0] addr, wdata, rdata;
    logic [NFUNC-1:0] fn_out, fn_oe, fn_in, routed;
    logic [NPIN-1:0] pad_in, pad_out, pad_oe, pad_pu, pad_an, ext_en, ext_val;
    int bad_count = 0;
    int n_tests = 0;
    int fn_tab [7] = '{0, 2, 3, 4, 5, 6, 7};
    int pin_tab [7] = '{4, 1, 2, 3, 6, 7, 8};
    // System clock
    always #2 clk = !clk;
    pcpc_top pcpc_top_i (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SPI_NSS_MODE(nss), .FN_OUT(fn_out),
        .FN_OE(fn_oe), .FN_IN(fn_in), .FN_ROUTED(routed), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu), .PAD_ANALOG(pad_an));
    pcpc_board pcpc_board_i (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pu), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad_in));
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(40'(rdata), 40'(exp));
    endtask
    // One function pulls low; only its pad may enable
    task automatic pin_of(input int fn, input int pin);
        fn_oe = '0;
        fn_oe[fn] = 1'b1;
        settle(2);
        chk(40'(pad_oe[NXPIN-1:0]), 40'h1 << pin);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #40000;
        bad_count++;
        final_report();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {wr, rd, addr, wdata, nss} = '0;
        {fn_out, fn_oe, ext_en, ext_val} = '0;
        settle(2);
        rst_n = 1'b1;
        chk(pad_an, '0);
        chk(pad_pu, '1);
        rd_reg(FSEL0_ADDR, FSEL_RST);
        rd_reg(FSEL1_ADDR, FSEL_RST);
        wr_reg(FSEL2_ADDR, 8'hFF);
        rd_reg(FSEL2_ADDR, 8'h03);
        rd_reg(8'h00, RD_NONE);
        wr_reg(FSEL2_ADDR, 8'h00);
        // Selections ignored while crossbar off; port 4 still drives
        wr_reg(FSEL0_ADDR, 8'hFF);
        wr_reg(LATCH_ADDR[4], 8'h00);
        settle(1);
        chk(40'(routed), '0);
        chk(pad_oe, {8'hFF, 32'h0});
        wr_reg(LATCH_ADDR[4], 8'hFF);
        // Skip, selects, then enable last
        wr_reg(SKIP_ADDR[0], 8'h01);
        wr_reg(FSEL0_ADDR, 8'h07);
        wr_reg(FSEL1_ADDR, 8'h40);
        settle(1);
        chk(40'(routed), 40'hDF);
        nss = 2'h1;
        settle(2);
        chk(40'(routed), 40'hFF);
        for (int i = 0; i < 7; i++) begin
            pin_of(fn_tab[i], pin_tab[i]);
        end
        // Push-pull transmit; two-wire data stays open-drain
        wr_reg(MDOUT_ADDR[0], 8'hFF);
        fn_oe = 25'h0000041;
        fn_out = 25'h0000041;
        settle(2);
        chk(40'({pad_oe[7], pad_out[4], pad_oe[4], pad_pu[7], pad_pu[4]}), 40'h0E);
        fn_out = 25'h0000000;
        settle(2);
        chk(40'({pad_oe[7], pad_out[7], pad_pu[7]}), 40'h4);
        // Analog pins lose driver and pull-up
        wr_reg(MDIN_ADDR[0], 8'hEE);
        fn_out = 25'h0000001;
        settle(1);
        chk(40'({pad_an[7:0], pad_oe[4], pad_pu[4]}), 40'h044);
        wr_reg(MDIN_ADDR[0], 8'hFF);
        wr_reg(MDOUT_ADDR[0], 8'h00);
        // Board levels reach the receive input and the port read
        fn_oe = '0;
        ext_en = 40'h000000FF20;
        ext_val = 40'h000000A500;
        settle(6);
        chk(40'(fn_in[1]), '0);
        rd_reg(LATCH_ADDR[1], 8'hA5);
        // Pull-up disable, then every counter module code
        wr_reg(FSEL1_ADDR, 8'hC0);
        settle(1);
        chk(pad_pu, '0);
        for (int c = 0; c < 8; c++) begin
            wr_reg(FSEL1_ADDR, 8'h40 | 8'(c));
            settle(1);
            chk(40'(routed[17:13]), (c > 5) ? 40'h0 : 40'((1 << c) - 1));
        end
        // Second bus and serial port land behind the first functions
        ext_en = '0;
        wr_reg(MDOUT_ADDR[1], 8'hFF);
        wr_reg(FSEL2_ADDR, 8'h03);
        settle(1);
        chk(40'(routed), 40'h1E000FF);
        fn_oe = 25'h0A00000;
        fn_out = 25'h0A00000;
        settle(2);
        chk(40'({pad_oe[9], pad_oe[11], pad_out[11]}), 40'h3);
        // Serial port 0 dropped while enabled; later functions move down
        wr_reg(FSEL0_ADDR, 8'h06);
        settle(1);
        chk(40'({routed[1:0], pad_oe[9], pad_out[9]}), 40'h3);
        final_report();
    end
endmodule
